//--- wdt_defines.svh
/*
 * Constants for the RC pin watchdog controller: register address, field
 * positions, reset values, command values and stretch timing.
 * Assumes a 100 MHz system clock; one cycle time equals one clock cycle.
 */
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// Register address of the control register.
`define WDT_CTRL_ADDR     16'hfe0f
// Field positions inside the control register.
`define WDT_BIT_RUN       0
`define WDT_BIT_RST       1
`define WDT_BIT_CLR       2
`define WDT_BIT_HLT       4
`define WDT_BIT_SPARE     5
`define WDT_BIT_FLAG      7
// Reset value of the control register.
`define WDT_CTRL_RESET    8'h00
// Mask of bits that exist; the rest read as zero.
`define WDT_CTRL_MASK     8'hb7
// Write value that clears a running watchdog.
`define WDT_CLEAR_CMD     8'h55
// Write value that starts a discharge while the watchdog is stopped.
`define WDT_DISCHARGE_CMD 8'h04
// Stretch time in cycle times, least value allowed.
`define WDT_STRETCH_TCYC  1920
// Stretch cycles derived from cycle time (10 ns) per clock (10 ns).
`define WDT_STRETCH_CYC   ((`WDT_STRETCH_TCYC * 10 + 9) / 10)
// Stretch counter width.
`define WDT_STRETCH_W     11

`endif

//--- wdt_pkg.sv
/*
 * Types shared by the watchdog controller files.
 * Assumes wdt_defines.svh is compiled alongside.
 */
package wdt_pkg;
    // Watchdog activity state.
    typedef enum logic [1:0] {
        idle_t_st,
        running_st,
        tripped_st
    } wdt_state_t;
endpackage

//--- wdt_stretch.sv
/*
 * Pulse stretcher: keeps the discharge transistor on for a fixed number of
 * cycles after each trigger pulse.
 * Assumes a single clock and triggers synchronous to it.
 */
`timescale 1ns/1ps
`include "wdt_defines.svh"
module wdt_stretch #(
    parameter int CYCLES = `WDT_STRETCH_CYC
) (
    input  wire logic clk,      // System clock.
    input  wire logic nrst,     // Asynchronous active low reset.
    input  wire logic trigger,  // One cycle pulse starting a stretch.
    output logic      active    // High while the stretch runs.
);
    // Remaining stretch cycles.
    logic [`WDT_STRETCH_W-1:0] remain;

    // Each trigger reloads the full count, then it counts down to zero.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            remain <= '0;
        end else if (trigger) begin
            remain <= `WDT_STRETCH_W'(CYCLES);
        end else if (remain != '0) begin
            remain <= remain - `WDT_STRETCH_W'(1);
        end
    end

    // The stretch is active while cycles remain.
    assign active = (remain != '0);

    // A trigger keeps the output on for at least the next 8 cycles.
    chk_stretch_span: assert property (@(posedge clk) disable iff (!nrst)
        trigger |=> active [*8]) else $error("Stretch ended too early.");
endmodule

//--- wdt_detect.sv
/*
 * Runaway detector: turns the high-threshold pin level into a one-cycle
 * runaway event on its rising edge.
 * Assumes the level input is synchronous to the clock.
 */
`timescale 1ns/1ps
module wdt_detect (
    input  wire logic clk,        // System clock.
    input  wire logic nrst,       // Asynchronous active low reset.
    input  wire logic high_level, // High-threshold pin level.
    input  wire logic enable,     // Detection allowed.
    output logic      event_out   // One cycle runaway event.
);
    // Previous sampled level.
    logic last;

    // Record the level each cycle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last <= 1'b0;
        end else begin
            last <= high_level;
        end
    end

    // A rising level is a runaway while detection is allowed.
    assign event_out = enable && high_level && !last;

    // The event only ever follows a low-to-high change while enabled.
    chk_detect_edge: assert property (@(posedge clk) disable iff (!nrst)
        event_out |-> (enable && !$past(high_level))) else $error("Event without edge.");
endmodule

//--- wdt_ctrl.sv
/*
 * RC pin watchdog controller. Holds the 8-bit control register, drives the
 * open-drain discharge transistor through a pulse stretcher, and turns a
 * rise to high level on the watchdog pin into a reset request or interrupt.
 * Assumes pin inputs are synchronous to clk and the port register logic
 * outside supplies the port configuration, with the pin set open drain.
 * Assumes the bus master holds each strobe for one cycle and takes read
 * data in the cycle after its read strobe.
 * Assumes the reset request and the interrupt zero pulse are caught by
 * logic outside, which restarts the processor or vectors it.
 */
`timescale 1ns/1ps
`include "wdt_defines.svh"
module wdt_ctrl #(
    parameter int STRETCH_CYCLES = `WDT_STRETCH_CYC
) (
    input  wire logic        clk,            // System clock, 100 MHz.
    input  wire logic        nrst,           // Reset pin, asynchronous, active low.
    input  wire logic [15:0] addr,           // Register address.
    input  wire logic [7:0]  wdata,          // Write data.
    input  wire logic        wr,             // Write strobe.
    input  wire logic        rd,             // Read strobe.
    output logic      [7:0]  rdata,          // Read data, one cycle after rd.
    input  wire logic        pin_high,       // High-threshold buffer level.
    input  wire logic        pin_port_in,    // Port-level input of the pin.
    output logic             pin_port_data,  // Pin port data as software reads it.
    output logic             pin_out,        // Pin output, always low when driven.
    output logic             pin_oe_n,       // Pin drive enable, low drives low.
    input  wire logic        low_power,      // Entry to halt or hold, one cycle.
    output logic             system_reset,   // Runaway reset request pulse.
    output logic             ext_int_zero,   // Interrupt zero request pulse.
    output logic             running         // Watchdog runs.
);
    // Control register bits.
    logic       runaway_flag;
    logic       spare_flag;
    logic       low_power_disable;
    logic       clear_enable;
    logic       reset_select;
    logic       run_bit;
    // Decoded accesses.
    logic       sel;
    logic       wr_ctrl;
    logic       clear_write;
    logic       plain_write;
    logic       gate_stop;
    // Stretcher trigger and state.
    logic       stretch_trig;
    logic       stretch_on;
    // Runaway event.
    logic       runaway;
    // Watchdog activity state.
    wdt_pkg::wdt_state_t state;
    // Width of the discharge run counter, one bit above the stretch counter.
    localparam int LEN_W = `WDT_STRETCH_W + 1;
    // Length of the present discharge run in clock cycles; saturates.
    logic [LEN_W-1:0] drive_len;

    // Address decode helper used for both strobes.
    function automatic logic hit(input logic [15:0] a);
        hit = (a == `WDT_CTRL_ADDR);
    endfunction

    assign sel = hit(addr);
    assign wr_ctrl = wr && sel;

    // A clear write is 55h while running; others are blocked then.
    assign clear_write = wr_ctrl && run_bit && (wdata == `WDT_CLEAR_CMD);
    assign plain_write = wr_ctrl && !run_bit;

    // Halt or hold entry stops the watchdog only when gated by the bit.
    assign gate_stop = low_power && low_power_disable;

    // Run bit: set by software, never cleared by software.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run_bit <= 1'b0;
        end else if (gate_stop) begin
            run_bit <= 1'b0;
        end else if (plain_write && wdata[`WDT_BIT_RUN]) begin
            run_bit <= 1'b1;
        end
    end

    // Clear-enable and reset-select: writable only while stopped.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            clear_enable <= 1'b0;
            reset_select <= 1'b0;
        end else if (gate_stop) begin
            clear_enable <= 1'b0;
            reset_select <= 1'b0;
        end else if (plain_write) begin
            clear_enable <= wdata[`WDT_BIT_CLR];
            reset_select <= wdata[`WDT_BIT_RST];
        end
    end

    // Low-power-disable and spare flag: writable only while stopped.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_power_disable <= 1'b0;
            spare_flag        <= 1'b0;
        end else if (plain_write) begin
            low_power_disable <= wdata[`WDT_BIT_HLT];
            spare_flag        <= wdata[`WDT_BIT_SPARE];
        end
    end

    // Runaway flag: hardware set wins over a software clear.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            runaway_flag <= 1'b0;
        end else if (runaway && reset_select) begin
            runaway_flag <= 1'b1;
        end else if (plain_write) begin
            runaway_flag <= wdata[`WDT_BIT_FLAG];
        end
    end

    // Activity state, used only by the checks; software cannot read it.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= wdt_pkg::idle_t_st;
        end else begin
            unique case (state)
                wdt_pkg::idle_t_st: begin
                    if (plain_write && wdata[`WDT_BIT_RUN] && !gate_stop) begin
                        state <= wdt_pkg::running_st;
                    end
                end
                wdt_pkg::running_st: begin
                    if (gate_stop) begin
                        state <= wdt_pkg::idle_t_st;
                    end else if (runaway) begin
                        state <= wdt_pkg::tripped_st;
                    end
                end
                wdt_pkg::tripped_st: begin
                    if (gate_stop) begin
                        state <= wdt_pkg::idle_t_st;
                    end else if (clear_write) begin
                        state <= wdt_pkg::running_st;
                    end
                end
                // The fourth code of the state vector is illegal; fall back to idle.
                default: begin
                    state <= wdt_pkg::idle_t_st;
                end
            endcase
        end
    end

    assign running = run_bit;

    // Trigger the stretcher on a clear write with clear-enable set, and also while stopped with
    // clear-enable set, which also covers the 04h discharge write.
    // Leaving clear-enable set while stopped keeps the transistor on and
    // draws current through the external resistor for as long as it lasts.
    assign stretch_trig = (clear_write && clear_enable)
                        || (!run_bit && clear_enable);

    // Pulse stretcher holding the transistor on.
    wdt_stretch #(
        .CYCLES (STRETCH_CYCLES)
    ) u_stretch (
        .clk     (clk),
        .nrst    (nrst),
        .trigger (stretch_trig),
        .active  (stretch_on)
    );

    // Open-drain pin: only ever pulls low.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_oe_n <= 1'b1;
        end else begin
            pin_oe_n <= !(stretch_on || stretch_trig);
        end
    end
    assign pin_out = 1'b0;

    // Discharge run length for the stretch check. The count restarts each
    // time the pin is released and stops at its top value, so a long idle
    // discharge cannot wrap round and look like a short one. It feeds only
    // the check below and has no effect on the pin.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            drive_len <= '0;
        end else if (pin_oe_n) begin
            drive_len <= '0; // Pin released: start again.
        end else if (drive_len != '1) begin
            drive_len <= drive_len + LEN_W'(1); // One more low cycle.
        end
    end

    // Port data read of the pin reflects its level; low reads 0.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_port_data <= 1'b0;
        end else begin
            pin_port_data <= pin_port_in;
        end
    end

    // Detection runs while running, or always when reset-select is set.
    // The detector follows the pin even while disabled, so enabling it with
    // the pin already high raises nothing until the pin falls and rises.
    wdt_detect u_detect (
        .clk        (clk),
        .nrst       (nrst),
        .high_level (pin_high),
        .enable     (run_bit || reset_select),
        .event_out  (runaway)
    );

    // Runaway responses: reset request or interrupt zero.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            system_reset <= 1'b0;
            ext_int_zero <= 1'b0;
        end else begin
            system_reset <= runaway && reset_select;
            ext_int_zero <= runaway && !reset_select;
        end
    end

    // Read data, one cycle after the strobe; absent bits read zero.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (rd && sel) begin
            rdata <= {runaway_flag, 1'b0, spare_flag, low_power_disable,
                      1'b0, clear_enable, reset_select, run_bit} & `WDT_CTRL_MASK;
        end else begin
            rdata <= 8'h00;
        end
    end

    // Writes while running never change the run bit or config.
    chk_write_lock: assert property (@(posedge clk) disable iff (!nrst)
        (run_bit && wr_ctrl && !gate_stop) |=> (run_bit && $stable(reset_select)))
        else $error("Locked register changed.");
    // A gated low-power entry clears run, clear and reset bits.
    chk_lp_stop: assert property (@(posedge clk) disable iff (!nrst)
        gate_stop |=> (!run_bit && !clear_enable && !reset_select))
        else $error("Low power did not stop watchdog.");
    // Clear write with clear-enable set drives the pin low on the next cycle.
    chk_clear_drive: assert property (@(posedge clk) disable iff (!nrst)
        (clear_write && clear_enable) |=> !pin_oe_n) else $error("Clear did not discharge.");
    // Runaway with reset-select gives flag and reset next cycle.
    chk_reset_flag: assert property (@(posedge clk) disable iff (!nrst)
        (runaway && reset_select) |=> (runaway_flag && system_reset))
        else $error("Runaway reset missing.");
    // Runaway without reset-select gives interrupt, no reset.
    chk_int_zero: assert property (@(posedge clk) disable iff (!nrst)
        (runaway && !reset_select) |=> (ext_int_zero && !system_reset))
        else $error("Interrupt zero missing.");
    // The flag never falls unless software writes while stopped.
    chk_flag_hold: assert property (@(posedge clk) disable iff (!nrst)
        (runaway_flag && !plain_write) |=> runaway_flag) else $error("Flag cleared itself.");
    // Clear-enable while stopped drives the pin on the next cycle.
    chk_idle_drive: assert property (@(posedge clk) disable iff (!nrst)
        (!run_bit && clear_enable) |=> !pin_oe_n) else $error("Idle discharge missing.");
    // Reset-select detection works with the watchdog stopped.
    chk_idle_reset: assert property (@(posedge clk) disable iff (!nrst)
        (!run_bit && reset_select && runaway) |=> system_reset)
        else $error("Idle reset missing.");
    // Read data follow a register read in the next cycle.
    chk_read_data: assert property (@(posedge clk) disable iff (!nrst)
        (rd && sel) |=> (rdata[`WDT_BIT_RUN] == $past(run_bit)))
        else $error("Read data wrong.");

    // A write of 04h while stopped turns the transistor on two edges later,
    // once the new clear-enable bit has reached the stretcher trigger.
    chk_discharge_cmd: assert property (@(posedge clk) disable iff (!nrst)
        (plain_write && !gate_stop && (wdata == `WDT_DISCHARGE_CMD)) |=> ##1 !pin_oe_n)
        else $error("Discharge write did not drive the pin.");

    // The pin is never released before a full stretch has been counted.
    chk_stretch_min: assert property (@(posedge clk) disable iff (!nrst)
        $rose(pin_oe_n) |-> (drive_len >= STRETCH_CYCLES))
        else $error("Discharge ended before the stretch time.");

    // Port data follow a low pin level one cycle later.
    chk_port_low: assert property (@(posedge clk) disable iff (!nrst)
        !pin_port_in |=> !pin_port_data)
        else $error("Low pin read as one.");

    // The activity state and the run bit always agree.
    chk_state_run: assert property (@(posedge clk) disable iff (!nrst)
        ((state == wdt_pkg::idle_t_st) == !run_bit))
        else $error("State and run bit disagree.");

    // Once running, only a gated low-power entry clears the run bit.
    chk_run_sticky: assert property (@(posedge clk) disable iff (!nrst)
        (run_bit && !gate_stop) |=> run_bit)
        else $error("Run bit fell without a stop.");

    // A gated low-power entry keeps the low-power-disable bit itself.
    chk_stop_keeps: assert property (@(posedge clk) disable iff (!nrst)
        (gate_stop && !plain_write) |=> $stable(low_power_disable))
        else $error("Low power entry changed its own bit.");

    // Writes while running leave the spare and low-power bits alone.
    chk_bits_lock: assert property (@(posedge clk) disable iff (!nrst)
        (run_bit && wr_ctrl) |=> ($stable(spare_flag) && $stable(low_power_disable)))
        else $error("Locked bits changed.");

    // A write while stopped loads the flag, unless a runaway sets it.
    chk_flag_write: assert property (@(posedge clk) disable iff (!nrst)
        (plain_write && !(runaway && reset_select))
            |=> (runaway_flag == $past(wdata[`WDT_BIT_FLAG])))
        else $error("Flag write not taken.");

    // Reset requests last one cycle each.
    chk_reset_pulse: assert property (@(posedge clk) disable iff (!nrst)
        system_reset |=> !system_reset)
        else $error("Reset request longer than a cycle.");

    // Interrupt requests last one cycle each.
    chk_int_pulse: assert property (@(posedge clk) disable iff (!nrst)
        ext_int_zero |=> !ext_int_zero)
        else $error("Interrupt request longer than a cycle.");

    // A stopped watchdog without reset-select raises no interrupt.
    chk_idle_quiet: assert property (@(posedge clk) disable iff (!nrst)
        (!run_bit && !reset_select) |=> !ext_int_zero)
        else $error("Interrupt while stopped.");
endmodule

//--- rc_net_model.sv
/*
 * Behavioural model of the external RC network on the watchdog pin.
 * Assumes the block pulls the pin low while pin_oe_n is low; otherwise
 * the capacitor charges one step per cycle, or every other cycle if slow.
 */
`timescale 1ns/1ps
module rc_net_model (
    input  wire logic clk,         // System clock.
    input  wire logic pin_oe_n,    // Low while the transistor discharges.
    input  wire logic slow,        // Charge at half rate.
    output logic      pin_high,    // High-threshold buffer level.
    output logic      pin_port_in  // Port-level input of the pin.
);
    // The capacitor starts charged, as after a long power-up.
    logic [5:0] level = 6'h3f;  // Capacitor charge in steps.
    logic       half  = 1'b0;   // Toggles to halve the charge rate.

    // The transistor drains fast; the resistor charges slowly.
    always_ff @(posedge clk) begin
        half <= ~half;
        if (pin_oe_n === 1'b0) begin
            level <= (level > 6'h08) ? level - 6'h08 : 6'h00;
        end else if (level != 6'h3f && (!slow || half)) begin
            level <= level + 6'h01;
        end
    end

    // The watchdog threshold sits above the port threshold.
    assign pin_high = (level >= 6'h3c);
    assign pin_port_in = (level >= 6'h1e);
endmodule

//--- rc_pin_watchdog_control_test.sv
/*
 * Self-checking testbench of the watchdog controller with an RC model.
 * Assumes a shortened stretch of 16 cycles and the one-cycle register bus.
 */
`timescale 1ns/1ps
`include "wdt_defines.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin $display("[ERR] %s exp %0h got %0h", nm, e, g); err_count++; end end
module rc_pin_watchdog_control_test;
    localparam int STRETCH = 16;  // Shortened stretch length.
    logic        clk, nrst, wr, rd, low_power, slow;  // Bench-driven controls.
    logic [15:0] addr;            // Register address.
    logic [7:0]  wdata, rdata;    // Bus data.
    logic        pin_high, pin_port_in, pin_port_data, pin_out, pin_oe_n;  // Pin side.
    logic        system_reset, ext_int_zero, running;  // Block results.
    int          err_count, n_compared, cyc, n_rst, n_int, n, i;  // Bookkeeping.
    logic [7:0]  rv, d;           // Read value and random data.

    wdt_ctrl #(.STRETCH_CYCLES(STRETCH)) i_dut (.clk(clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_high(pin_high),
        .pin_port_in(pin_port_in), .pin_port_data(pin_port_data), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .low_power(low_power), .system_reset(system_reset),
        .ext_int_zero(ext_int_zero), .running(running));
    rc_net_model i_rc (.clk(clk), .pin_oe_n(pin_oe_n), .slow(slow), .pin_high(pin_high),
        .pin_port_in(pin_port_in));

    // Clock of 10 ns.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Counts cycles with each request high, and cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (system_reset === 1'b1) n_rst++;
        if (ext_int_zero === 1'b1) n_int++;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end

    // Expected register after a write: locked while running.
    function automatic logic [7:0] after_wr(input logic [7:0] old, input logic [7:0] v);
        return old[`WDT_BIT_RUN] ? old : (v & `WDT_CTRL_MASK);
    endfunction

    task results;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task do_reset;
        nrst <= 1'b0;
        repeat (10) @(posedge clk);
        n_rst = 0;
        n_int = 0;
        nrst <= 1'b1;
    endtask

    task wr_reg(input logic [7:0] v);
        @(posedge clk);
        addr <= `WDT_CTRL_ADDR;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task rd_reg(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    // Counts the cycles the transistor stays on after a write.
    task stretch_len;
        #1;
        n = 0;
        while (pin_oe_n === 1'b0 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    // Turns the transistor on and waits for the pin to read low.
    task discharge;
        wr_reg(8'h04);
        @(posedge clk);
        #1;
        n = 0;
        while (pin_port_data !== 1'b0 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("discharge on", 1'b0, pin_oe_n)
        `CHK("pin data low", 1'b0, pin_port_data)
        `CHK("pin out", 1'b0, pin_out)
    endtask

    // Waits for a reset or interrupt request, then lets it end.
    task wait_evt;
        n = 0;
        while (n_rst + n_int == 0 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        repeat (3) @(posedge clk);
    endtask

    task low_pulse;
        @(posedge clk);
        low_power <= 1'b1;
        @(posedge clk);
        low_power <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // Main sequence.
    initial begin
        nrst = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 16'h0000;
        wdata = 8'h00;
        low_power = 1'b0;
        slow = 1'b0;
        err_count = 0;
        n_compared = 0;
        cyc = 0;
        void'($urandom(6));
        do_reset();
        rd_reg(`WDT_CTRL_ADDR, rv);
        `CHK("ctrl reset", `WDT_CTRL_RESET, rv)
        rd_reg(16'hfe10, rv);
        `CHK("unmapped", 8'h00, rv)
        discharge();
        rd_reg(`WDT_CTRL_ADDR, rv);
        `CHK("ctrl 04", 8'h04, rv)
        $display("test discharge done");
        wr_reg(8'h07);
        repeat (30) @(posedge clk);
        for (i = 0; i < 6; i++) begin
            d = 8'($urandom);
            if (d == `WDT_CLEAR_CMD) d = 8'h56;
            wr_reg(d);
            rd_reg(`WDT_CTRL_ADDR, rv);
            `CHK("locked", after_wr(8'h07, d), rv)
        end
        wr_reg(`WDT_CLEAR_CMD);
        stretch_len();
        `CHK("stretch", STRETCH + 1, n)
        repeat (5 + $urandom % 10) @(posedge clk);
        wr_reg(`WDT_CLEAR_CMD);
        repeat (5) @(posedge clk);
        wr_reg(`WDT_CLEAR_CMD);
        stretch_len();
        `CHK("restretch", STRETCH + 1, n)
        `CHK("no early event", 0, n_rst + n_int)
        wait_evt();
        `CHK("reset pulse", 1, n_rst)
        `CHK("no int", 0, n_int)
        rd_reg(`WDT_CTRL_ADDR, rv);
        `CHK("flag set", 8'h87, rv)
        repeat (50) @(posedge clk);
        rd_reg(`WDT_CTRL_ADDR, rv);
        `CHK("flag kept", 8'h87, rv)
        do_reset();
        rd_reg(`WDT_CTRL_ADDR, rv);
        `CHK("ctrl cleared", 8'h00, rv)
        $display("test reset path done");
        discharge();
        slow <= 1'($urandom);
        wr_reg(8'h05);
        wait_evt();
        `CHK("int pulse", 1, n_int)
        `CHK("no reset", 0, n_rst)
        rd_reg(`WDT_CTRL_ADDR, rv);
        `CHK("no flag", 8'h05, rv)
        low_pulse();
        `CHK("keeps running", 1'b1, running)
        $display("test interrupt path done");
        do_reset();
        discharge();
        wr_reg(8'h15);
        low_pulse();
        `CHK("stopped", 1'b0, running)
        rd_reg(`WDT_CTRL_ADDR, rv);
        `CHK("low power clear", 8'h10, rv)
        $display("test low power done");
        discharge();
        wr_reg(8'h02);
        wait_evt();
        `CHK("idle reset", 1, n_rst)
        rd_reg(`WDT_CTRL_ADDR, rv);
        `CHK("idle flag", 8'h82, rv)
        wr_reg(8'h20);
        rd_reg(`WDT_CTRL_ADDR, rv);
        `CHK("flag cleared", 8'h20, rv)
        $display("test idle reset done");
        results();
    end
endmodule
